// ==== pscr_cfg.svh ====
/*
 * Constants of the PHY status and pattern checker register bank: register
 * indexes, field positions, reset values and bus widths.
 * Assumes it is included by bare name from files that need these values.
 */
`ifndef PSCR_CFG_SVH
`define PSCR_CFG_SVH

// Bus widths; registers are 16 bits wide in the low half of the data word.
`define PSCR_ADDR_W        12
`define PSCR_DATA_W        32
`define PSCR_REG_W         16
`define PSCR_IDX_W         8
`define PSCR_IDX_LSB       2

// Register indexes; the byte address is four times the index.
`define PSCR_IDX_SKEW      8'h55
`define PSCR_IDX_STRAP1    8'h6e
`define PSCR_IDX_STRAP2    8'h6f
`define PSCR_IDX_BYTES     8'h71
`define PSCR_IDX_ERRSTS    8'h72
`define PSCR_IDX_CTRL      8'h80
`define PSCR_IDX_IRQ_STS   8'h81
`define PSCR_IDX_IRQ_MASK  8'h82

// Field positions in the error status register.
`define PSCR_BIT_LOCK      0
`define PSCR_BIT_CLEAR     1
`define PSCR_BIT_BYTE_OVF  9
`define PSCR_BIT_PKT_OVF   10

// Counter widths, maxima and reset values.
`define PSCR_BYTE_W 16
`define PSCR_ERR_W 8
`define PSCR_PKT_W 16
`define PSCR_BYTE_MAX 16'hffff
`define PSCR_ERR_MAX 8'hff
`define PSCR_PKT_MAX 16'hffff
`define PSCR_ZERO16 16'h0000
`define PSCR_ZERO8 8'h00
`define PSCR_ZERO32 32'h0000_0000

// Control register: count mode field and its reset value.
`define PSCR_MODE_W        2
`define PSCR_MODE_RST      2'h0
`define PSCR_MODE_SAT      2'h0

// Interrupt status bits.
`define PSCR_IRQ_W 4
`define PSCR_IRQ_BYTE_OVF 0
`define PSCR_IRQ_PKT_OVF 1
`define PSCR_IRQ_ERR 2
`define PSCR_IRQ_LOCK 3
`define PSCR_IRQ_RST 4'h0

`endif

// ==== pscr_pkg.sv ====
/*
 * Types of the PHY status and pattern checker register bank.
 * Assumes pscr_cfg.svh is on the include path.
 */
package pscr_pkg;

    // Strap levels sampled once after reset.
    typedef struct packed {
        logic       mirror_enable;
        logic       downshift_enable;
        logic       strapped_clock_output_off;
        logic       strapped_parallel_mac_off;
        logic       serial_mac_enable;
        logic       strapped_auto_crossover_off;
        logic       strapped_crossover_force;
        logic       strapped_half_duplex;
        logic       strapped_negotiation_off;
        logic       strapped_negotiation_select;
        logic [3:0] strapped_mgmt_address;
        logic       strapped_quick_link_loss;
        logic [2:0] tx_clock_delay;
        logic [2:0] rx_clock_delay;
    } pscr_strap_t;

    // Per-byte events from the test-pattern checker.
    typedef struct packed {
        logic byte_valid;
        logic byte_error;
        logic packet_done;
    } pscr_chk_event_t;

    // Receive alignment skew of the two channels, in clock cycles.
    typedef struct packed {
        logic [3:0] chan_b_align_cycles;
        logic [3:0] chan_a_align_cycles;
    } pscr_skew_t;

endpackage

// ==== pscr_regs.sv ====
/*
 * APB register bank for PHY status: receive skew readout, latched strap
 * words and the test-pattern checker byte and error counters with lock and
 * lock-and-clear, a packet counter seen only through its overflow flag,
 * plus a small interrupt unit.
 * Assumes all inputs are synchronous to pclk and that straps are stable
 * while presetn is low and for the first clock after its release.
 */
`timescale 1ns/1ps
`include "pscr_cfg.svh"

// Notes on behaviour
// R01: Skew word shows channel B in 7:4, channel A in 3:0, reset zero.
// R02: Strap word one 15..11: mirror, downshift, clock, parallel, serial.
// R03: Strap word one 10..7: crossover off, force, duplex, negotiation off.
// R04: Strap word one: negotiation select bit 5, address 3:0, bits 6,4 zero.
// R05: Strap word two bit 10 shows the quick link loss strap.
// R06: Strap word two: transmit delay code 6:4, receive delay code 2:0.
// R07: A read-only 16-bit register holds total checker bytes received.
// R08: Byte total visible value is captured on a write to bit 0 or 1.
// R09: With count mode zero the byte counter saturates at its maximum.
// R10: Error byte count sits in 7:0 and saturates when mode is zero.
// R11: Error byte field is captured on a write to bit 0 or 1.
// R12: Packet overflow flag at bit 10 stays set until counters clear.
// R13: Byte overflow flag at bit 9 stays set until counters clear.
// R14: Writing one to bit 1 clears both overflow flags.
// R15: Writing bit 0 captures the byte and error counters without clearing them.
// R16: Writing bit 1 captures the counters and then zeroes them.
// R17: With nonzero mode counters wrap to zero; byte and packet counters set their overflow flag.
module pscr_regs
    import pscr_pkg::*;
(
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [`PSCR_ADDR_W-1:0]   paddr,
    input  wire logic [`PSCR_DATA_W-1:0]   pwdata,
    output logic      [`PSCR_DATA_W-1:0]   prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire pscr_strap_t               strap_pins,
    input  wire pscr_skew_t                rx_skew,
    input  wire pscr_chk_event_t           chk_event,
    output logic                           checker_lock_pulse,
    output logic                           checker_clear_pulse,
    output logic                           irq
);

    // Decodes a bus address to its register index.
    function automatic logic [`PSCR_IDX_W-1:0] reg_index(
        input logic [`PSCR_ADDR_W-1:0] addr
    );
        reg_index = addr[`PSCR_IDX_LSB +: `PSCR_IDX_W];
    endfunction

    // True when an index names a register of this bank.
    function automatic logic index_mapped(
        input logic [`PSCR_IDX_W-1:0] idx
    );
        unique case (idx)
            `PSCR_IDX_SKEW,
            `PSCR_IDX_STRAP1,
            `PSCR_IDX_STRAP2,
            `PSCR_IDX_BYTES,
            `PSCR_IDX_ERRSTS,
            `PSCR_IDX_CTRL,
            `PSCR_IDX_IRQ_STS,
            `PSCR_IDX_IRQ_MASK: index_mapped = 1'b1;
            default:            index_mapped = 1'b0;
        endcase
    endfunction

    logic [`PSCR_IDX_W-1:0]  bus_idx;
    logic                    bus_mapped;
    logic                    access_phase;
    logic                    wr_stb;
    logic                    wr_errsts;
    logic                    lock_req;
    logic                    clear_req;
    logic                    saturate;

    pscr_strap_t             strap_reg;
    logic                    strap_taken_reg;
    pscr_skew_t              skew_reg;
    logic [`PSCR_MODE_W-1:0] mode_reg;
    logic [`PSCR_IRQ_W-1:0]  irq_sts_reg;
    logic [`PSCR_IRQ_W-1:0]  irq_sts_next;
    logic [`PSCR_IRQ_W-1:0]  irq_mask_reg;
    logic [`PSCR_IRQ_W-1:0]  irq_event;

    logic [`PSCR_BYTE_W-1:0] byte_cnt_reg;
    logic [`PSCR_BYTE_W-1:0] byte_cnt_next;
    logic [`PSCR_ERR_W-1:0]  err_cnt_reg;
    logic [`PSCR_ERR_W-1:0]  err_cnt_next;
    logic [`PSCR_PKT_W-1:0]  pkt_cnt_reg;
    logic [`PSCR_PKT_W-1:0]  pkt_cnt_next;
    logic                    byte_hit_max;
    logic                    err_hit_max;
    logic                    pkt_hit_max;
    logic [`PSCR_BYTE_W-1:0] byte_snap_reg;
    logic [`PSCR_ERR_W-1:0]  err_snap_reg;
    logic                    byte_ovf_reg;
    logic                    pkt_ovf_reg;
    logic [`PSCR_REG_W-1:0]  rd_value;

    // Bus decode; the slave is ready in every access phase.
    assign bus_idx      = reg_index(paddr);
    assign bus_mapped   = index_mapped(bus_idx);
    assign access_phase = psel & penable;
    assign pready       = access_phase;
    assign pslverr      = access_phase & ~bus_mapped;
    assign wr_stb       = access_phase & pwrite & bus_mapped;
    assign wr_errsts    = wr_stb & (bus_idx == `PSCR_IDX_ERRSTS);

    // A clear also locks, so either bit raises the capture.
    assign clear_req = wr_errsts & pwdata[`PSCR_BIT_CLEAR];          // R16
    assign lock_req  = wr_errsts & (pwdata[`PSCR_BIT_LOCK]
                                    | pwdata[`PSCR_BIT_CLEAR]);      // R15
    assign checker_lock_pulse  = lock_req;
    assign checker_clear_pulse = clear_req;

    // Count mode zero means saturate; any other value means wrap.
    assign saturate = (mode_reg == `PSCR_MODE_SAT);

    // Straps are caught on the first edge after reset release and then
    // held; an asynchronous reset may only load constants, so the pins
    // cannot be taken while presetn is low.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            strap_taken_reg <= 1'b0;
            strap_reg       <= '0;
        end
        else if (!strap_taken_reg)
        begin
            strap_taken_reg <= 1'b1;
            strap_reg       <= strap_pins;                           // R02
        end
    end

    // Skew readout follows the aligner and starts at zero.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            skew_reg <= '0;                                          // R01
        end
        else
        begin
            skew_reg <= rx_skew;                                     // R01
        end
    end

    // Control and interrupt mask registers written by software.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode_reg     <= `PSCR_MODE_RST;
            irq_mask_reg <= `PSCR_IRQ_RST;
        end
        else if (wr_stb)
        begin
            if (bus_idx == `PSCR_IDX_CTRL)
            begin
                mode_reg <= pwdata[`PSCR_MODE_W-1:0];
            end
            if (bus_idx == `PSCR_IDX_IRQ_MASK)
            begin
                irq_mask_reg <= pwdata[`PSCR_IRQ_W-1:0];
            end
        end
    end

    // Next values of the live counters: saturate or wrap per mode,
    // and a clear zeroes them after the snapshot has been taken.
    always_comb
    begin
        byte_hit_max  = chk_event.byte_valid
                        & (byte_cnt_reg == `PSCR_BYTE_MAX);
        err_hit_max   = chk_event.byte_valid & chk_event.byte_error
                        & (err_cnt_reg == `PSCR_ERR_MAX);
        pkt_hit_max   = chk_event.packet_done
                        & (pkt_cnt_reg == `PSCR_PKT_MAX);
        byte_cnt_next = byte_cnt_reg;
        err_cnt_next  = err_cnt_reg;
        pkt_cnt_next  = pkt_cnt_reg;
        if (clear_req)
        begin
            byte_cnt_next = `PSCR_ZERO16;                            // R16
            err_cnt_next  = `PSCR_ZERO8;                             // R16
            pkt_cnt_next  = `PSCR_ZERO16;                            // R16
        end
        else
        begin
            if (chk_event.byte_valid && !(byte_hit_max && saturate))
            begin
                byte_cnt_next = byte_cnt_reg + 1'b1;                 // R17
            end
            if (chk_event.byte_valid && chk_event.byte_error
                && !(err_hit_max && saturate))
            begin
                err_cnt_next = err_cnt_reg + 1'b1;                   // R17
            end
            if (chk_event.packet_done && !(pkt_hit_max && saturate))
            begin
                pkt_cnt_next = pkt_cnt_reg + 1'b1;                   // R17
            end
        end
    end

    // Live counters; in saturate mode the increment is withheld at max.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            byte_cnt_reg <= `PSCR_ZERO16;
            err_cnt_reg  <= `PSCR_ZERO8;
            pkt_cnt_reg  <= `PSCR_ZERO16;
        end
        else
        begin
            byte_cnt_reg <= byte_cnt_next;                           // R09
            err_cnt_reg  <= err_cnt_next;                            // R10
            pkt_cnt_reg  <= pkt_cnt_next;
        end
    end

    // Visible values only change on a lock, so software reads a
    // consistent pair even while the checker keeps receiving.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            byte_snap_reg <= `PSCR_ZERO16;
            err_snap_reg  <= `PSCR_ZERO8;
        end
        else if (lock_req)
        begin
            byte_snap_reg <= byte_cnt_reg;                           // R08
            err_snap_reg  <= err_cnt_reg;                            // R11
        end
    end

    // Overflow flags are sticky until a clear; an overflow landing in
    // the clear cycle wins so that it is not lost.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            byte_ovf_reg <= 1'b0;
            pkt_ovf_reg  <= 1'b0;
        end
        else
        begin
            if (byte_hit_max)
            begin
                byte_ovf_reg <= 1'b1;                                // R13
            end
            else if (clear_req)
            begin
                byte_ovf_reg <= 1'b0;                                // R14
            end
            if (pkt_hit_max)
            begin
                pkt_ovf_reg <= 1'b1;                                 // R12
            end
            else if (clear_req)
            begin
                pkt_ovf_reg <= 1'b0;                                 // R14
            end
        end
    end

    // Interrupt events: overflows, error bytes and completed locks.
    always_comb
    begin
        irq_event = '0;
        irq_event[`PSCR_IRQ_BYTE_OVF] = byte_hit_max;
        irq_event[`PSCR_IRQ_PKT_OVF]  = pkt_hit_max;
        irq_event[`PSCR_IRQ_ERR]      = chk_event.byte_valid
                                        & chk_event.byte_error;
        irq_event[`PSCR_IRQ_LOCK]     = lock_req;
    end

    // Write-one-to-clear status; a new event in the same cycle wins.
    always_comb
    begin
        irq_sts_next = irq_sts_reg;
        if (wr_stb && bus_idx == `PSCR_IDX_IRQ_STS)
        begin
            irq_sts_next = irq_sts_reg & ~pwdata[`PSCR_IRQ_W-1:0];
        end
        irq_sts_next = irq_sts_next | irq_event;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_sts_reg <= `PSCR_IRQ_RST;
        end
        else
        begin
            irq_sts_reg <= irq_sts_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq <= 1'b0;
        end
        else
        begin
            irq <= |(irq_sts_next & irq_mask_reg);
        end
    end

    // Read multiplexer; reserved bits and unmapped indexes read zero.
    always_comb
    begin
        rd_value = `PSCR_ZERO16;
        unique case (bus_idx)
            `PSCR_IDX_SKEW:
            begin
                rd_value[7:4] = skew_reg.chan_b_align_cycles;        // R01
                rd_value[3:0] = skew_reg.chan_a_align_cycles;        // R01
            end
            `PSCR_IDX_STRAP1:
            begin
                rd_value[15] = strap_reg.mirror_enable;              // R02
                rd_value[14] = strap_reg.downshift_enable;           // R02
                rd_value[13] = strap_reg.strapped_clock_output_off;  // R02
                rd_value[12] = strap_reg.strapped_parallel_mac_off;  // R02
                rd_value[11] = strap_reg.serial_mac_enable;          // R02
                rd_value[10] = strap_reg.strapped_auto_crossover_off;// R03
                rd_value[9]  = strap_reg.strapped_crossover_force;   // R03
                rd_value[8]  = strap_reg.strapped_half_duplex;       // R03
                rd_value[7]  = strap_reg.strapped_negotiation_off;   // R03
                rd_value[5]  = strap_reg.strapped_negotiation_select;// R04
                rd_value[3:0] = strap_reg.strapped_mgmt_address;     // R04
            end
            `PSCR_IDX_STRAP2:
            begin
                rd_value[10]  = strap_reg.strapped_quick_link_loss;  // R05
                rd_value[6:4] = strap_reg.tx_clock_delay;            // R06
                rd_value[2:0] = strap_reg.rx_clock_delay;            // R06
            end
            `PSCR_IDX_BYTES:
            begin
                rd_value = byte_snap_reg;                            // R07
            end
            `PSCR_IDX_ERRSTS:
            begin
                rd_value[`PSCR_BIT_PKT_OVF]  = pkt_ovf_reg;          // R12
                rd_value[`PSCR_BIT_BYTE_OVF] = byte_ovf_reg;         // R13
                rd_value[`PSCR_ERR_W-1:0]    = err_snap_reg;         // R10
            end
            `PSCR_IDX_CTRL:
            begin
                rd_value[`PSCR_MODE_W-1:0] = mode_reg;
            end
            `PSCR_IDX_IRQ_STS:
            begin
                rd_value[`PSCR_IRQ_W-1:0] = irq_sts_reg;
            end
            `PSCR_IDX_IRQ_MASK:
            begin
                rd_value[`PSCR_IRQ_W-1:0] = irq_mask_reg;
            end
            default:
            begin
                rd_value = `PSCR_ZERO16;
            end
        endcase
    end

    // Read data is registered in the setup phase so that it is stable
    // from a flip-flop throughout the access phase.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= `PSCR_ZERO32;
        end
        else if (psel && !penable && !pwrite)
        begin
            prdata <= {{(`PSCR_DATA_W-`PSCR_REG_W){1'b0}}, rd_value};
        end
    end

endmodule // pscr_regs

// ==== pscr_regs_monitor.sv ====
/* Assertions on the PHY status register bank, bound to pscr_regs.
   Assumes one pclk domain and presetn as async active-low reset. */
`timescale 1ns/1ps
`include "pscr_cfg.svh"
module pscr_regs_monitor
    import pscr_pkg::*;
(
    input wire logic                    pclk,
    input wire logic                    presetn,
    input wire logic                    psel,
    input wire logic                    penable,
    input wire logic                    pwrite,
    input wire logic [`PSCR_ADDR_W-1:0] paddr,
    input wire logic [`PSCR_DATA_W-1:0] pwdata,
    input wire logic [`PSCR_DATA_W-1:0] prdata,
    input wire logic                    pready,
    input wire logic                    pslverr,
    input wire pscr_strap_t             strap_pins,
    input wire pscr_skew_t              rx_skew,
    input wire pscr_chk_event_t         chk_event,
    input wire logic                    checker_lock_pulse,
    input wire logic                    checker_clear_pulse,
    input wire logic                    irq
);
    logic [7:0] idx;
    logic       rd;
    logic       wr_es;
    logic       mapped;
    // Access decode shared by the properties below.
    assign idx    = paddr[9:2];
    assign rd     = psel && penable && !pwrite;
    assign wr_es  = psel && penable && pwrite && idx == `PSCR_IDX_ERRSTS;
    assign mapped = idx inside {`PSCR_IDX_SKEW, `PSCR_IDX_STRAP1,
        `PSCR_IDX_STRAP2, `PSCR_IDX_BYTES, `PSCR_IDX_ERRSTS,
        `PSCR_IDX_CTRL, `PSCR_IDX_IRQ_STS, `PSCR_IDX_IRQ_MASK};

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_ready; psel && penable |-> pready && pslverr == !mapped;
    endproperty
    a_ready: assert property (p_ready)
        else $error("bad access answer");
    property p_lock; wr_es && |pwdata[1:0] |-> checker_lock_pulse; endproperty
    a_lock: assert property (p_lock)
        else $error("no lock pulse");
    property p_clear; wr_es && pwdata[1] |-> checker_clear_pulse &&
        checker_lock_pulse; endproperty
    a_clear: assert property (p_clear)
        else $error("no lock and clear pulse");
    property p_only_lock; wr_es && pwdata[1:0] == 2'b01 |->
        !checker_clear_pulse; endproperty
    a_only_lock: assert property (p_only_lock)
        else $error("lock write cleared");
    property p_quiet; !wr_es |-> !checker_lock_pulse && !checker_clear_pulse;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("stray checker pulse");
    property p_skew; rd && idx == `PSCR_IDX_SKEW |->
        prdata == {24'h0, $past(rx_skew, 2)}; endproperty
    a_skew: assert property (p_skew)
        else $error("skew word wrong");
    property p_strap1; rd && idx == `PSCR_IDX_STRAP1 |->
        prdata[31:16] == 16'h0 && !prdata[6] && !prdata[4]; endproperty
    a_strap1: assert property (p_strap1)
        else $error("strap one reserved bits");
    property p_strap2; rd && idx == `PSCR_IDX_STRAP2 |-> prdata[15:11] == 5'h0
        && prdata[9:7] == 3'h0 && !prdata[3]; endproperty
    a_strap2: assert property (p_strap2)
        else $error("strap two reserved bits");
    property p_errsts; rd && idx == `PSCR_IDX_ERRSTS |->
        prdata[31:11] == 21'h0 && !prdata[8]; endproperty
    a_errsts: assert property (p_errsts)
        else $error("status reserved bits");

    // Main scenarios: plain lock, lock with clear, refused access.
    c_lock: cover property (checker_lock_pulse && !checker_clear_pulse);
    c_clear: cover property (checker_clear_pulse);
    c_refused: cover property (psel && penable && pslverr);
endmodule // pscr_regs_monitor

bind pscr_regs pscr_regs_monitor i_mon (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .strap_pins,
    .rx_skew, .chk_event, .checker_lock_pulse, .checker_clear_pulse, .irq);

// ==== pscr_apb_master.sv ====
/* Behavioural APB controller standing for the management side.
   Assumes a free-running pclk and a slave that answers with pready. */
`timescale 1ns/1ps
module pscr_apb_master
(
    input  wire logic        pclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    logic hung;
    // Idle bus at time zero.
    initial
    begin
        {hung, psel, penable, pwrite, paddr, pwdata} = 48'h0;
    end

    // One transfer; released address and data are inverted, not held.
    task automatic xfer(input logic w, input logic [7:0] idx,
        input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (!pready && n < 64);
        hung = hung | !pready;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~paddr;
        pwdata <= ~pwdata;
    endtask
endmodule // pscr_apb_master

// ==== test_phy_status_prbs_counter_regs.sv ====
/* Self-checking bench of the PHY status register bank.
   Assumes the master model and monitor are compiled with it. */
`timescale 1ns/1ps
`include "pscr_cfg.svh"
module test_phy_status_prbs_counter_regs
    import pscr_pkg::*;
();
    logic            pclk;
    logic            presetn;
    wire             psel, penable, pwrite, pready, pslverr, irq;
    wire             checker_lock_pulse, checker_clear_pulse;
    wire [11:0]      paddr;
    wire [31:0]      pwdata, prdata;
    pscr_strap_t     strap_pins;
    pscr_skew_t      rx_skew;
    pscr_chk_event_t chk_event;
    logic [32:0]     q[$];
    int              mismatches, check_count, nb, ne;

    pscr_regs i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .strap_pins, .rx_skew,
        .chk_event, .checker_lock_pulse, .checker_clear_pulse, .irq);
    pscr_apb_master i_mst (.pclk, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr);

    // Free-running 100 MHz clock.
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic chk(input string nm, input logic [32:0] e,
        input logic [32:0] s);
        check_count++;
        if (s !== e)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic summarize();
        if (i_mst.hung)
            mismatches++;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Each completed read meets the oldest expectation, error bit on top.
    always @(posedge pclk)
        if (psel && penable && pready && !pwrite)
        begin
            if (q.size() == 0)
                chk("read queue", 33'h0, 33'h1);
            else
                chk("read", q.pop_front(), {pslverr, prdata});
        end

    // Bus wrappers; a hung transfer ends the run at once.
    task automatic rd(input logic [7:0] idx, input logic [16:0] e);
        q.push_back({e[16], 16'h0, e[15:0]});
        i_mst.xfer(1'b0, idx, 32'h0);
        if (i_mst.hung)
            summarize();
    endtask
    task automatic wr(input logic [7:0] idx, input logic [15:0] v);
        i_mst.xfer(1'b1, idx, {16'h0, v});
        if (i_mst.hung)
            summarize();
    endtask
    task automatic lk(input logic [1:0] b);
        wr(`PSCR_IDX_ERRSTS, {14'h0, b});
    endtask
    task automatic ick(input logic e);
        repeat (2) @(posedge pclk);
        #1;
        chk("irq", {32'h0, e}, {32'h0, irq});
    endtask

    // Checker bytes, each closing a packet; errors on all or at random.
    task automatic ev(input int n, input logic all);
        logic e;
        repeat (n)
        begin
            @(posedge pclk);
            e = all | 1'($urandom);
            chk_event <= '{1'b1, e, 1'b1};
            nb++;
            ne += int'(e);
        end
        @(posedge pclk);
        chk_event <= '0;
    endtask

    // Main sequence; straps are fixed before reset is released.
    initial
    begin
        pscr_strap_t s;
        pscr_skew_t  sk;
        logic [15:0] v;
        logic [15:0] u;
        mismatches = 0;
        check_count = 0;
        presetn = 1'b0;
        chk_event = '0;
        rx_skew = '0;
        void'($urandom(32'hd24a));
        s = pscr_strap_t'(21'($urandom));
        strap_pins = s;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        rd(`PSCR_IDX_SKEW, 17'h0);
        sk = pscr_skew_t'(8'($urandom));
        rx_skew <= sk;
        @(posedge pclk); // Skew is registered.
        rd(`PSCR_IDX_SKEW, {9'h0, sk});
        rd(`PSCR_IDX_STRAP1, {1'b0, s.mirror_enable, s.downshift_enable,
            s.strapped_clock_output_off, s.strapped_parallel_mac_off,
            s.serial_mac_enable, s.strapped_auto_crossover_off,
            s.strapped_crossover_force, s.strapped_half_duplex,
            s.strapped_negotiation_off, 1'b0, s.strapped_negotiation_select,
            1'b0, s.strapped_mgmt_address});
        rd(`PSCR_IDX_STRAP2, {6'h0, s.strapped_quick_link_loss, 3'h0,
            s.tx_clock_delay, 1'b0, s.rx_clock_delay});
        $display("test status words done");
        lk(2'b10);
        nb = 0;
        ne = 0;
        ev(50 + $urandom_range(20), 1'b0);
        lk(2'b01);
        rd(`PSCR_IDX_BYTES, 17'(nb));
        rd(`PSCR_IDX_ERRSTS, 17'(ne));
        wr(`PSCR_IDX_BYTES, 16'h5a5a);
        v = 16'(nb);
        u = 16'(ne);
        ev(9, 1'b0);
        rd(`PSCR_IDX_BYTES, {1'b0, v});
        rd(`PSCR_IDX_ERRSTS, {1'b0, u});
        lk(2'b10);
        rd(`PSCR_IDX_BYTES, 17'(nb));
        rd(`PSCR_IDX_ERRSTS, 17'(ne));
        lk(2'b01);
        rd(`PSCR_IDX_BYTES, 17'h0);
        $display("test lock and clear done");
        ev(65540, 1'b1);
        lk(2'b01);
        rd(`PSCR_IDX_BYTES, 17'hffff);
        rd(`PSCR_IDX_ERRSTS, 17'h06ff);
        rd(`PSCR_IDX_IRQ_STS, 17'h000f);
        lk(2'b10);
        lk(2'b01);
        rd(`PSCR_IDX_ERRSTS, 17'h0);
        $display("test saturation done");
        ick(1'b0);
        wr(`PSCR_IDX_IRQ_MASK, 16'h0001);
        ick(1'b1);
        wr(`PSCR_IDX_IRQ_STS, 16'h0001);
        ick(1'b0);
        rd(`PSCR_IDX_IRQ_STS, 17'h000e);
        $display("test interrupt done");
        wr(`PSCR_IDX_CTRL, 16'h0001);
        lk(2'b10);
        ev(260, 1'b1);
        lk(2'b01);
        rd(`PSCR_IDX_BYTES, 17'd260);
        rd(`PSCR_IDX_ERRSTS, 17'h0004);
        rd(8'h10, 17'h1_0000);
        $display("test wrap and refusal done");
        summarize();
    end

    // Watchdog for a hang outside the bounded bus waits.
    initial
    begin
        #900_000;
        mismatches++;
        summarize();
    end
endmodule // test_phy_status_prbs_counter_regs
